/* hdl/oag_defs.svh */
/*
 * Constants of the operand address generator: mode codes, widths, page limits.
 * Assumes inclusion by the package, the generator module and the testbench.
 */
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// (RULE1) Seventeen addressing modes in seven groups are decoded: inherent, immediate, direct, indexed, indirect, relative, bit.
// (RULE2) Long forms build a 16-bit address over the whole 64 Kbyte space and take more bytes and cycles.
// (RULE3) Short forms keep the address in page zero, 0000h to 00FFh, from one address byte; here the short indexed modes reach up to 01FE.
// (RULE4) Read-modify-write instructions take only short forms; a long form with them is refused.
// (RULE5) Indirect indexed reads the pointer address after the opcode, fetches the pointer, then adds X or Y unsigned.
// (RULE6) Short indirect indexed fetches a one-byte pointer, reaching 00 to 1FE.
// (RULE7) Long indirect indexed fetches a two-byte pointer, reaching the whole 64 Kbyte space.
// (RULE8) Relative modes add an 8-bit two's-complement offset to the program counter.
// (RULE9) Direct relative takes the offset from the byte right after the opcode.
// (RULE10) Indirect relative reads an address after the opcode, then fetches the offset from there.
// (RULE11) The offset is added to the address of the instruction following the whole branch.
//////////////////////////////////////////////////////////////////////////////
`ifndef OAG_DEFS_SVH
`define OAG_DEFS_SVH

`define OAG_ADDR_W      16
`define OAG_DATA_W      8
`define OAG_MODE_W      5
`define OAG_PAGE0_MAX   16'h00FF
`define OAG_IIX_MAX     16'h01FE
`define OAG_PC_RST      16'h0000

`define OAG_M_INH       5'h00
`define OAG_M_IMM       5'h01
`define OAG_M_DIR_S     5'h02
`define OAG_M_DIR_L     5'h03
`define OAG_M_IX0       5'h04
`define OAG_M_IX_S      5'h05
`define OAG_M_IX_L      5'h06
`define OAG_M_IND_S     5'h07
`define OAG_M_IND_L     5'h08
`define OAG_M_IIX_S     5'h09
`define OAG_M_IIX_L     5'h0A
`define OAG_M_REL_D     5'h0B
`define OAG_M_REL_I     5'h0C
`define OAG_M_BIT_D     5'h0D
`define OAG_M_BIT_I     5'h0E
`define OAG_M_BIT_DR    5'h0F
`define OAG_M_BIT_IR    5'h10

`endif

/* hdl/oag_pkg.sv */
/*
 * Types of the operand address generator.
 * Assumes oag_defs.svh sits on the include path.
 */
`include "oag_defs.svh"

package oag_pkg;

    typedef struct packed {
        logic [`OAG_MODE_W-1:0] mode;
        logic                   rmw;
        logic                   use_y;
        logic [`OAG_ADDR_W-1:0] pc;
    } oag_req_t;

    typedef struct packed {
        logic                   ea_valid;
        logic [`OAG_ADDR_W-1:0] ea;
        logic                   pc_valid;
        logic [`OAG_ADDR_W-1:0] pc;
        logic                   fault;
    } oag_res_t;

    typedef enum logic [6:0] {
        OAG_IDLE = 7'h01,
        OAG_OP1  = 7'h02,
        OAG_OP2  = 7'h04,
        OAG_OP3  = 7'h08,
        OAG_PTR1 = 7'h10,
        OAG_PTR2 = 7'h20,
        OAG_DONE = 7'h40
    } oag_state_t;

endpackage : oag_pkg

/* hdl/oag_gen.sv */
/*
 * Operand address generator: walks the operand bytes of one instruction,
 * fetches pointers or offsets and forms the effective address or new PC.
 * Assumes a synchronous memory on the same clock that answers one read with
 * mem_rvalid_i a fixed time later; X and Y come from the core on this clock.
 */
`include "oag_defs.svh"

module oag_gen
    import oag_pkg::*;
(
    input  wire logic                   core_clk_i,
    input  wire logic                   nrst_i,
    input  wire logic                   start_i,
    input  wire oag_req_t               req_i,
    input  wire logic [`OAG_DATA_W-1:0] idx_x_i,
    input  wire logic [`OAG_DATA_W-1:0] idx_y_i,
    input  wire logic                   mem_rvalid_i,
    input  wire logic [`OAG_DATA_W-1:0] mem_rdata_i,
    output logic                        mem_rd_o,
    output logic [`OAG_ADDR_W-1:0]      mem_addr_o,
    output logic                        busy_o,
    output oag_res_t                    res_o
);

    //////////////////////////////////////////////////////////////////////////
    // Mode decode
    function automatic logic [1:0] op_bytes(input logic [`OAG_MODE_W-1:0] m);
        case (m)
            `OAG_M_INH, `OAG_M_IX0:                        op_bytes = 2'd0;
            `OAG_M_DIR_L, `OAG_M_IX_L, `OAG_M_BIT_DR,
            `OAG_M_BIT_IR:                                 op_bytes = 2'd2;
            default:                                       op_bytes = 2'd1;   // see (RULE6)
        endcase
    endfunction : op_bytes

    function automatic logic is_long(input logic [`OAG_MODE_W-1:0] m);
        is_long = (m == `OAG_M_DIR_L) || (m == `OAG_M_IX_L) ||
                  (m == `OAG_M_IND_L) || (m == `OAG_M_IIX_L);
    endfunction : is_long

    function automatic logic [`OAG_ADDR_W-1:0] rel_add(input logic [`OAG_ADDR_W-1:0] p,
                                                        input logic [`OAG_DATA_W-1:0] o);
        rel_add = p + {{8{o[7]}}, o};   // see (RULE8)
    endfunction : rel_add

    oag_state_t               state_reg, state_next;
    oag_req_t                 req_reg;
    logic [`OAG_ADDR_W-1:0]   fa_reg, fa_next;
    logic [`OAG_DATA_W-1:0]   b1_reg, b2_reg;
    logic [1:0]               cnt_reg;
    logic                     wait_reg;
    logic                     mem_rd_reg, mem_rd_next;
    logic [`OAG_ADDR_W-1:0]   mem_addr_reg, mem_addr_next;
    oag_res_t                 res_reg, res_next;
    logic                     ack_req;
    logic                     busy_reg;

    wire logic [`OAG_MODE_W-1:0] m = req_reg.mode;
    wire logic [`OAG_DATA_W-1:0] idx = req_reg.use_y ? idx_y_i : idx_x_i;
    wire logic [`OAG_ADDR_W-1:0] idx16 = {8'h00, idx};
    wire logic [1:0]             nbytes = op_bytes(m);
    wire logic                   is_rel = (m == `OAG_M_REL_D) || (m == `OAG_M_REL_I);
    wire logic                   is_brel = (m == `OAG_M_BIT_DR) || (m == `OAG_M_BIT_IR);
    wire logic                   ptr_mode = (m == `OAG_M_IND_S) || (m == `OAG_M_IND_L) ||
                                            (m == `OAG_M_IIX_S) || (m == `OAG_M_IIX_L) ||
                                            (m == `OAG_M_REL_I) || (m == `OAG_M_BIT_I) ||
                                            (m == `OAG_M_BIT_IR);
    wire logic                   ptr_word = (m == `OAG_M_IND_L) || (m == `OAG_M_IIX_L);
    wire logic                   rmw_bad = req_reg.rmw && is_long(m);   // see (RULE4)
    // Next-instruction address: opcode plus operand bytes
    wire logic [`OAG_ADDR_W-1:0] pc_next_ins = req_reg.pc + 16'h0001 + {14'h0000, nbytes};  // see (RULE11)
    wire logic [`OAG_ADDR_W-1:0] fetch_addr = req_reg.pc + 16'h0001 + {14'h0000, cnt_reg};

    //////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        state_next    = state_reg;
        fa_next       = fa_reg;
        mem_rd_next   = 1'b0;
        mem_addr_next = mem_addr_reg;
        res_next      = res_reg;
        ack_req       = 1'b0;
        res_next.ea_valid = 1'b0;
        res_next.pc_valid = 1'b0;
        res_next.fault    = 1'b0;
        case (state_reg)
            OAG_IDLE: begin
                if (start_i) begin
                    ack_req    = 1'b1;
                    state_next = OAG_OP1;
                end
            end
            OAG_OP1: begin
                if (rmw_bad) begin
                    res_next.fault = 1'b1;   // see (RULE4)
                    state_next     = OAG_DONE;
                end else if (cnt_reg < nbytes) begin
                    if (!wait_reg) begin
                        mem_rd_next   = 1'b1;   // see (RULE9)
                        mem_addr_next = fetch_addr;
                    end
                end else if (ptr_mode) begin
                    // Pointer address is the byte after the opcode, page zero
                    mem_rd_next   = 1'b1;   // see (RULE5) see (RULE10)
                    mem_addr_next = {8'h00, b1_reg};
                    state_next    = OAG_PTR1;
                end else begin
                    state_next = OAG_OP2;
                end
            end
            OAG_PTR1: begin
                if (mem_rvalid_i) begin
                    if (ptr_word) begin
                        mem_rd_next   = 1'b1;   // see (RULE7)
                        mem_addr_next = {8'h00, b1_reg} + 16'h0001;
                        fa_next       = {mem_rdata_i, 8'h00};
                        state_next    = OAG_PTR2;
                    end else begin
                        fa_next    = {8'h00, mem_rdata_i};   // see (RULE6)
                        state_next = OAG_OP2;
                    end
                end
            end
            OAG_PTR2: begin
                if (mem_rvalid_i) begin
                    fa_next    = {fa_reg[15:8], mem_rdata_i};
                    state_next = OAG_OP2;
                end
            end
            OAG_OP2: begin
                res_next.pc = pc_next_ins;
                case (m)
                    `OAG_M_IMM:    res_next.ea = req_reg.pc + 16'h0001;
                    `OAG_M_DIR_S, `OAG_M_BIT_D, `OAG_M_BIT_DR:
                                   res_next.ea = {8'h00, b1_reg};   // see (RULE3)
                    `OAG_M_DIR_L:  res_next.ea = {b1_reg, b2_reg};   // see (RULE2)
                    `OAG_M_IX0:    res_next.ea = idx16;
                    `OAG_M_IX_S:   res_next.ea = {8'h00, b1_reg} + idx16;
                    `OAG_M_IX_L:   res_next.ea = {b1_reg, b2_reg} + idx16;
                    `OAG_M_IIX_S, `OAG_M_IIX_L:
                                   res_next.ea = fa_reg + idx16;   // see (RULE5)
                    `OAG_M_REL_D:  res_next.pc = rel_add(pc_next_ins, b1_reg);   // see (RULE9)
                    `OAG_M_REL_I:  res_next.pc = rel_add(pc_next_ins, fa_reg[7:0]);   // see (RULE10)
                    default:       res_next.ea = fa_reg;
                endcase
                // Bit test jumps carry their offset in the second operand byte
                if (is_brel)
                    res_next.pc = rel_add(pc_next_ins, b2_reg);   // see (RULE8)
                res_next.ea_valid = (m != `OAG_M_INH) && !is_rel;   // see (RULE1)
                res_next.pc_valid = 1'b1;
                state_next        = OAG_DONE;
            end
            OAG_DONE: begin
                state_next = OAG_IDLE;
            end
            default: begin
                state_next = OAG_IDLE;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg    <= OAG_IDLE;
            req_reg      <= '0;
            fa_reg       <= `OAG_PC_RST;
            mem_rd_reg   <= 1'b0;
            mem_addr_reg <= `OAG_PC_RST;
            res_reg      <= '0;
            busy_reg     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            fa_reg       <= fa_next;
            mem_rd_reg   <= mem_rd_next;
            mem_addr_reg <= mem_addr_next;
            res_reg      <= res_next;
            busy_reg     <= (state_next != OAG_IDLE);
            if (ack_req)
                req_reg <= req_i;
        end
    end

    // Operand byte capture
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_reg  <= 2'd0;
            wait_reg <= 1'b0;
            b1_reg   <= 8'h00;
            b2_reg   <= 8'h00;
        end else if (state_reg != OAG_OP1) begin
            cnt_reg  <= 2'd0;
            wait_reg <= 1'b0;
        end else if (mem_rd_next) begin
            wait_reg <= ptr_mode && cnt_reg >= nbytes ? 1'b0 : 1'b1;
        end else if (wait_reg && mem_rvalid_i) begin
            wait_reg <= 1'b0;
            cnt_reg  <= cnt_reg + 2'd1;
            case (cnt_reg)
                2'd0:    b1_reg <= mem_rdata_i;
                default: b2_reg <= mem_rdata_i;
            endcase
        end
    end

    assign mem_rd_o   = mem_rd_reg;
    assign mem_addr_o = mem_addr_reg;
    assign busy_o     = busy_reg;
    assign res_o      = res_reg;

    //////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_short_page0;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (res_o.ea_valid && (req_reg.mode == `OAG_M_DIR_S || req_reg.mode == `OAG_M_BIT_D))
        |-> (res_o.ea <= `OAG_PAGE0_MAX);
    endproperty
    a_short_page0: assert property (p_short_page0) else $error("short ea off page zero"); // see (RULE3)

    property p_iix_short_range;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (res_o.ea_valid && req_reg.mode == `OAG_M_IIX_S) |-> (res_o.ea <= `OAG_IIX_MAX);
    endproperty
    a_iix_short_range: assert property (p_iix_short_range) else $error("iix short range"); // see (RULE6)

    property p_rmw_fault;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (state_reg == OAG_OP1 && rmw_bad) |=> (res_o.fault && !res_o.ea_valid);
    endproperty
    a_rmw_fault: assert property (p_rmw_fault) else $error("long rmw not refused"); // see (RULE4)

    property p_rel_direct;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (state_reg == OAG_OP2 && m == `OAG_M_REL_D)
        |=> (res_o.pc == $past(req_reg.pc) + 16'h0002 + {{8{$past(b1_reg[7])}}, $past(b1_reg)});
    endproperty
    a_rel_direct: assert property (p_rel_direct) else $error("relative pc wrong"); // see (RULE8)

    property p_ptr_addr;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (state_reg == OAG_PTR1 && $past(state_reg) == OAG_OP1)
        |-> (mem_addr_o == {8'h00, b1_reg} && mem_rd_o);
    endproperty
    a_ptr_addr: assert property (p_ptr_addr) else $error("pointer address wrong"); // see (RULE5)

    property p_word_ptr;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (state_reg == OAG_PTR1 && mem_rvalid_i && ptr_word)
        |=> (state_reg == OAG_PTR2 && mem_addr_o == {8'h00, b1_reg} + 16'h0001);
    endproperty
    a_word_ptr: assert property (p_word_ptr) else $error("second pointer byte"); // see (RULE7)

    property p_long_dir;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (state_reg == OAG_OP2 && m == `OAG_M_DIR_L) |=> (res_o.ea == {b1_reg, b2_reg});
    endproperty
    a_long_dir: assert property (p_long_dir) else $error("long direct ea"); // see (RULE2)

    property p_inh_no_ea;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (state_reg == OAG_OP2 && m == `OAG_M_INH)
        |=> (!res_o.ea_valid && res_o.pc == $past(req_reg.pc) + 16'h0001);
    endproperty
    a_inh_no_ea: assert property (p_inh_no_ea) else $error("inherent result"); // see (RULE11)

    property p_rel_indirect;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (state_reg == OAG_OP2 && m == `OAG_M_REL_I)
        |=> (res_o.pc == $past(req_reg.pc) + 16'h0002 +
             {{8{$past(fa_reg[7])}}, $past(fa_reg[7:0])});
    endproperty
    a_rel_indirect: assert property (p_rel_indirect) else $error("rel ind pc"); // see (RULE10)

    property p_iix_add;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (state_reg == OAG_OP2 && (m == `OAG_M_IIX_S || m == `OAG_M_IIX_L))
        |=> (res_o.ea == $past(fa_reg) + {8'h00, $past(idx)});
    endproperty
    a_iix_add: assert property (p_iix_add) else $error("ind idx ea"); // see (RULE5)

    property p_rmw_no_fetch;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (state_reg == OAG_OP1 && rmw_bad) |=> (!mem_rd_o && state_reg == OAG_DONE);
    endproperty
    a_rmw_no_fetch: assert property (p_rmw_no_fetch) else $error("rmw fetched"); // see (RULE4)

    property p_bit_rel;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (state_reg == OAG_OP2 && is_brel)
        |=> (res_o.pc == $past(req_reg.pc) + 16'h0003 +
             {{8{$past(b2_reg[7])}}, $past(b2_reg)});
    endproperty
    a_bit_rel: assert property (p_bit_rel) else $error("bit jump pc"); // see (RULE11)

    c_rel_ind:  cover property (@(posedge core_clk_i) disable iff (!nrst_i)
        state_reg == OAG_OP2 && m == `OAG_M_REL_I);
    c_iix_long: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
        state_reg == OAG_OP2 && m == `OAG_M_IIX_L);
    c_fault:    cover property (@(posedge core_clk_i) disable iff (!nrst_i) res_o.fault);
    c_bit_rel:  cover property (@(posedge core_clk_i) disable iff (!nrst_i)
        state_reg == OAG_OP2 && is_brel);

endmodule : oag_gen

/* sim/oag_mem_model.sv */
/*
 * Memory model for the operand address generator: code, pointers and operands.
 * Assumes one read per mem_rd_i pulse; the bench fills mem and sets lat_i.
 */
module oag_mem_model (
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        mem_rd_i,
    input  wire logic [15:0] mem_addr_i,
    input  wire logic [3:0]  lat_i,
    output logic             mem_rvalid_o,
    output logic [7:0]       mem_rdata_o
);
    //////////////////////////////////////////////////////////////////////////
    // Storage and read pipeline
    logic [7:0]  mem [0:65535];
    logic        pend_reg;
    logic [15:0] addr_reg;
    logic [3:0]  cnt_reg;

    // Data toggles outside a valid beat so stale bytes never look good
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mem_rvalid_o <= 1'b0;
            mem_rdata_o  <= 8'h00;
            pend_reg     <= 1'b0;
            addr_reg     <= 16'h0000;
            cnt_reg      <= 4'h0;
        end else begin
            mem_rvalid_o <= 1'b0;
            mem_rdata_o  <= ~mem_rdata_o;
            if (mem_rd_i && lat_i == 4'h0) begin
                mem_rvalid_o <= 1'b1;
                mem_rdata_o  <= mem[mem_addr_i];
            end else if (mem_rd_i) begin
                pend_reg <= 1'b1;
                addr_reg <= mem_addr_i;
                cnt_reg  <= lat_i - 4'h1;
            end else if (pend_reg && cnt_reg == 4'h0) begin
                mem_rvalid_o <= 1'b1;
                mem_rdata_o  <= mem[addr_reg];
                pend_reg     <= 1'b0;
            end else if (pend_reg) begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end
endmodule : oag_mem_model

/* sim/testbench.sv */
/*
 * Self-checking bench of the operand address generator.
 * Assumes oag_gen, oag_pkg and oag_mem_model; memory is loaded by hierarchy.
 */
`include "oag_defs.svh"

module testbench
    import oag_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic       core_clk_i = 1'b0;
    logic       nrst_i     = 1'b0;
    logic       start_i    = 1'b0;
    oag_req_t   req_i      = '0;
    logic [7:0] idx_x_i    = 8'h00;
    logic [7:0] idx_y_i    = 8'h00;
    logic [3:0] lat        = 4'h0;
    logic       mem_rd_o;
    logic [15:0] mem_addr_o;
    logic       mem_rvalid;
    logic [7:0] mem_rdata;
    logic       busy_o;
    oag_res_t   res_o;
    oag_res_t   got;
    int         err_count = 0;
    int         n_tests   = 0;
    int         rd_cnt    = 0;
    int         rd_seen;

    always #2 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) if (mem_rd_o === 1'b1) rd_cnt <= rd_cnt + 1;

    oag_gen dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .start_i(start_i), .req_i(req_i),
        .idx_x_i(idx_x_i), .idx_y_i(idx_y_i), .mem_rvalid_i(mem_rvalid),
        .mem_rdata_i(mem_rdata), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
        .busy_o(busy_o), .res_o(res_o));

    oag_mem_model mem_model (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .mem_rd_i(mem_rd_o),
        .mem_addr_i(mem_addr_o), .lat_i(lat), .mem_rvalid_o(mem_rvalid),
        .mem_rdata_o(mem_rdata));

    //////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            $display("wrong value at %0t: %s", $time, msg);
            err_count++;
        end
    endtask : check

    task automatic run(input logic [4:0] mode, input logic rmw, input logic use_y,
                       input logic [15:0] pc);
        int base;
        int k;
        k = 0;
        while (busy_o !== 1'b0 && k < 100) begin
            @(posedge core_clk_i);
            k++;
        end
        @(posedge core_clk_i);
        base    = rd_cnt;
        start_i <= 1'b1;
        req_i   <= '{mode: mode, rmw: rmw, use_y: use_y, pc: pc};
        @(posedge core_clk_i);
        start_i <= 1'b0;
        for (k = 0; k < 200; k++) begin
            @(posedge core_clk_i);
            #1;
            if (res_o.pc_valid === 1'b1 || res_o.fault === 1'b1) break;
        end
        got     = res_o;
        rd_seen = rd_cnt - base;
        check(16'(k < 200), 16'h0001, "no result");
    endtask : run

    task automatic conclude();
        if (err_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    //////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_direct();
        mem_model.mem[16'h0101] = 8'h55;
        run(`OAG_M_DIR_S, 1'b0, 1'b0, 16'h0100);
        check(got.ea, 16'h0055, "short direct ea");
        check(got.pc, 16'h0102, "short direct pc");
        lat = 4'h3;
        mem_model.mem[16'h0201] = 8'h12;
        mem_model.mem[16'h0202] = 8'h34;
        run(`OAG_M_DIR_L, 1'b0, 1'b0, 16'h0200);
        check(got.ea, 16'h1234, "long direct ea");
        check(got.pc, 16'h0203, "long direct pc");
        check(16'(rd_seen), 16'h0002, "long direct reads");
        lat = 4'h0;
    endtask : t_direct

    task automatic t_ind_idx();
        mem_model.mem[16'h0301] = 8'h40;
        mem_model.mem[16'h0040] = 8'hFF;
        idx_y_i = 8'hFF;
        idx_x_i = 8'h01;
        run(`OAG_M_IIX_S, 1'b0, 1'b1, 16'h0300);
        check(got.ea, 16'h01FE, "short ind idx ea");
        check(16'(rd_seen), 16'h0002, "short ind idx reads");
        lat = 4'h2;
        mem_model.mem[16'h0401] = 8'hFE;
        mem_model.mem[16'h00FE] = 8'hFF;
        mem_model.mem[16'h00FF] = 8'h00;
        idx_x_i = 8'hFF;
        run(`OAG_M_IIX_L, 1'b0, 1'b0, 16'h0400);
        check(got.ea, 16'hFFFF, "long ind idx ea");
        check(16'(rd_seen), 16'h0003, "long ind idx reads");
        lat = 4'h0;
    endtask : t_ind_idx

    task automatic t_relative();
        mem_model.mem[16'h1001] = 8'h80;
        run(`OAG_M_REL_D, 1'b0, 1'b0, 16'h1000);
        check(got.pc, 16'h0F82, "rel direct pc");
        mem_model.mem[16'h2001] = 8'h30;
        mem_model.mem[16'h0030] = 8'h7F;
        run(`OAG_M_REL_I, 1'b0, 1'b0, 16'h2000);
        check(got.pc, 16'h2081, "rel indirect pc");
        check(16'(rd_seen), 16'h0002, "rel indirect reads");
    endtask : t_relative

    task automatic t_rmw();
        logic [4:0] longs [4];
        longs = '{`OAG_M_DIR_L, `OAG_M_IX_L, `OAG_M_IND_L, `OAG_M_IIX_L};
        foreach (longs[i]) begin
            run(longs[i], 1'b1, 1'b0, 16'h0600);
            check(16'(got.fault), 16'h0001, "long rmw fault");
            check(16'(rd_seen), 16'h0000, "long rmw fetch");
        end
        mem_model.mem[16'h0701] = 8'hA5;
        run(`OAG_M_DIR_S, 1'b1, 1'b0, 16'h0700);
        check(16'(got.fault), 16'h0000, "short rmw fault");
        check(got.ea, 16'h00A5, "short rmw ea");
    endtask : t_rmw

    task automatic t_all_modes();
        logic [15:0] ea_exp [17];
        logic [15:0] pc_exp [17];
        logic [16:0] eav_exp;
        ea_exp  = '{16'h0000, 16'h0501, 16'h0010, 16'h1010, 16'h0003, 16'h0013, 16'h1013,
                    16'h0020, 16'h2000, 16'h0023, 16'h2003, 16'h0000, 16'h0000, 16'h0010,
                    16'h0020, 16'h0010, 16'h0020};
        pc_exp  = '{16'h0501, 16'h0502, 16'h0502, 16'h0503, 16'h0501, 16'h0502, 16'h0503,
                    16'h0502, 16'h0502, 16'h0502, 16'h0502, 16'h0512, 16'h0522, 16'h0502,
                    16'h0502, 16'h0513, 16'h0513};
        eav_exp = 17'h1E7FE;
        idx_x_i = 8'h03;
        for (int m = 0; m < 17; m++) begin
            mem_model.mem[16'h0501] = 8'h10;
            mem_model.mem[16'h0502] = 8'h10;
            mem_model.mem[16'h0503] = 8'h10;
            mem_model.mem[16'h0010] = 8'h20;
            mem_model.mem[16'h0011] = 8'h00;
            run(5'(m), 1'b0, 1'b0, 16'h0500);
            check(16'(got.fault), 16'h0000, "mode faulted");
            check(16'(got.pc_valid), 16'h0001, "mode no pc");
            check(16'(got.ea_valid), 16'(eav_exp[m]), "mode ea valid");
            check(got.pc, pc_exp[m], "mode pc");
            if (eav_exp[m])
                check(got.ea, ea_exp[m], "mode ea");
        end
    endtask : t_all_modes

    task automatic t_reset();
        mem_model.mem[16'h0801] = 8'h44;
        while (busy_o !== 1'b0) begin
            @(posedge core_clk_i);
        end
        @(posedge core_clk_i);
        start_i <= 1'b1;
        req_i   <= '{mode: `OAG_M_DIR_L, rmw: 1'b0, use_y: 1'b0, pc: 16'h0800};
        @(posedge core_clk_i);
        start_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        check(16'(busy_o), 16'h0001, "busy before reset");
        @(posedge core_clk_i);
        nrst_i <= 1'b0;
        #1;
        check(16'(busy_o), 16'h0000, "busy in reset");
        check(16'(mem_rd_o), 16'h0000, "read in reset");
        check(mem_addr_o, 16'h0000, "address in reset");
        check(16'(res_o.pc_valid), 16'h0000, "result in reset");
        repeat (4) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        run(`OAG_M_DIR_S, 1'b0, 1'b0, 16'h0800);
        check(got.ea, 16'h0044, "ea after reset");
        check(got.pc, 16'h0802, "pc after reset");
    endtask : t_reset

    //////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        repeat (16) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        t_direct();
        t_ind_idx();
        t_relative();
        t_rmw();
        t_all_modes();
        t_reset();
        conclude();
    end

    initial begin
        #40000;
        err_count++;
        conclude();
    end
endmodule : testbench
